//--- rtl/cpd_defines.svh
/*
  Register offsets, field positions, reset values and boost length for the
  configurable port pin driver. Assumes inclusion by bare name from rtl/.
*/
`ifndef CPD_DEFINES_SVH
`define CPD_DEFINES_SVH

// Word-aligned byte offsets on the Wishbone slave
`define CPD_OFS_P1_LATCH   8'h00
`define CPD_OFS_P1_MODE    8'h04
`define CPD_OFS_P3_LATCH   8'h08
`define CPD_OFS_P3_MODE0   8'h0C
`define CPD_OFS_P3_MODE1   8'h10
`define CPD_OFS_P4_LATCH   8'h14
`define CPD_OFS_P4_MODE    8'h18
`define CPD_OFS_PULLUP     8'h1C
`define CPD_OFS_SYSCFG     8'h20
`define CPD_OFS_P1_PIN     8'h24
`define CPD_OFS_P3_PIN     8'h28
`define CPD_OFS_P4_PIN     8'h2C

// Reset values
`define CPD_RST_LATCH      8'hFF
`define CPD_RST_MODE       8'h00
`define CPD_RST_P4_LATCH   2'h3
`define CPD_RST_P4_MODE    2'h0
`define CPD_RST_SYSCFG     2'h0

// Fields of the system configuration register
`define CPD_SYSCFG_XTAL    0
`define CPD_SYSCFG_RSTGPIO 1

// Strong pull-up boost length in CPU clocks
`define CPD_BOOST_CYCLES   1

`endif

//--- rtl/cpd_pkg.sv
/*
  Types for the configurable port pin driver. Assumes nothing beyond the
  compiler; constants live in cpd_defines.svh.
*/
package cpd_pkg;

  // Port 3 mode encoding, {mode0, mode1}
  typedef enum logic [1:0]
  {
    CPD_P3_QUASI = 2'h0,
    CPD_P3_PUSH  = 2'h1,
    CPD_P3_INPUT = 2'h2,
    CPD_P3_OPEN  = 2'h3
  } cpd_p3_mode_type;

  // Wishbone slave answer state, Gray along idle -> ack
  typedef enum logic
  {
    CPD_WB_IDLE = 1'b0,
    CPD_WB_ACK  = 1'b1
  } cpd_wb_state_type;

endpackage

//--- rtl/cpd_pin_cell.sv
/*
  One pin's output stage decode and input synchroniser. Assumes mclk runs
  continuously and the pin input may be asynchronous to it.
*/
`timescale 1ns/1ps
`include "cpd_defines.svh"

module cpd_pin_cell
#(
  parameter bit FOUR_MODE = 1'b1
)
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       latch_bit,
  input  wire logic [1:0] mode_bits,
  input  wire logic       pullup_en,
  input  wire logic       release_pin,
  input  wire logic       pin_in,
  output logic            pin_sync,
  output logic            pull_down,
  output logic            strong_up,
  output logic            weak_up,
  output logic            very_weak_up
);

  logic sync1_reg;
  logic sync1_next;
  logic sync2_reg;
  logic sync2_next;
  logic latch_q_reg;
  logic latch_q_next;
  logic [1:0] boost_reg;
  logic [1:0] boost_next;
  cpd_pkg::cpd_p3_mode_type mode;

  assign mode     = cpd_pkg::cpd_p3_mode_type'(mode_bits);
  assign pin_sync = sync2_reg;

  // Next state: synchroniser, latch history and boost counter
  always_comb
  begin
    sync1_next   = pin_in;
    sync2_next   = sync1_reg;
    latch_q_next = latch_bit;
    boost_next   = (boost_reg != 2'h0) ? boost_reg - 2'h1 : 2'h0;
    if (latch_bit && !latch_q_reg)
    begin
      boost_next = 2'(`CPD_BOOST_CYCLES);
    end
  end

  // Registers; latch history resets to one so no boost after reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg   <= 1'b0;
      sync2_reg   <= 1'b0;
      latch_q_reg <= 1'b1;
      boost_reg   <= 2'h0;
    end
    else
    begin
      sync1_reg   <= sync1_next;
      sync2_reg   <= sync2_next;
      latch_q_reg <= latch_q_next;
      boost_reg   <= boost_next;
    end
  end

  // Driver decode; a released pin has every transistor off
  always_comb
  begin
    pull_down    = 1'b0;
    strong_up    = 1'b0;
    weak_up      = 1'b0;
    very_weak_up = 1'b0;
    if (release_pin)
    begin
      pull_down = 1'b0;
    end
    else if (FOUR_MODE)
    begin
      unique case (mode)
        cpd_pkg::CPD_P3_QUASI:
        begin
          pull_down    = !latch_bit;
          very_weak_up = latch_bit;
          weak_up      = latch_bit && sync2_reg;
          strong_up    = latch_bit && (boost_reg != 2'h0);
        end
        cpd_pkg::CPD_P3_PUSH:
        begin
          pull_down = !latch_bit;
          strong_up = latch_bit;
        end
        cpd_pkg::CPD_P3_INPUT:
        begin
          pull_down = 1'b0;
        end
        cpd_pkg::CPD_P3_OPEN:
        begin
          pull_down = !latch_bit;
        end
      endcase
    end
    else
    begin
      pull_down = !latch_bit;
      if (mode_bits[0])
      begin
        strong_up = latch_bit;
      end
      else
      begin
        weak_up = latch_bit && pullup_en;
      end
    end
  end

endmodule

//--- rtl/cpd_port_driver.sv
/*
  Configurable port pin driver: Wishbone register file plus one pin cell per
  port pin (Port 1 eight pins, Port 3 eight pins, Port 4 two pins).
  Assumes a classic Wishbone master on mclk and pads that turn the drive
  controls into pin levels.
*/
// Summary of operation
// - Quasi-bidirectional pin drives high only weakly, usable as input and output.
// - Quasi-bidirectional with latch zero drives strong pull-down.
// - Very weak pull-up on whenever latch holds one in quasi mode.
// - In quasi mode, weak pull-up on only when latch one and sampled pin one.
// - External low on a latched-one pin drops weak, keeps very weak pull-up.
// - Latch zero-to-one in quasi mode gives one clock of strong pull-up.
// - Port 3 push-pull: strong pull-up while latch one, normal pull-down otherwise.
// - Push-pull reads use the same synchronised input path as quasi mode.
// - Each Port 3 pin independently selects among four modes.
// - Other pins: push-pull or open-drain, software pull-up in open-drain on Port 1 only.
// - Crystal selected hands both Port 4 pins to the oscillator, released.
// - Reset pin can serve as Port 3 bit six.
// - Port 3 mode bits: 00 quasi, 01 push-pull, 10 input, 11 open-drain.
// - Input-only mode disables all pull-ups and the pull-down.
// - Port 3 open-drain: no pull-ups, pull-down only while latch is zero.
// - General pin mode bit: zero open-drain, one push-pull.
`timescale 1ns/1ps
`include "cpd_defines.svh"

module cpd_port_driver
#(
  parameter int NPINS = 18
)
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic [NPINS-1:0] pin_in,
  output logic      [NPINS-1:0] pin_pull_down,
  output logic      [NPINS-1:0] pin_strong_up,
  output logic      [NPINS-1:0] pin_weak_up,
  output logic      [NPINS-1:0] pin_very_weak_up,
  output logic                  crystal_select,
  output logic                  port3_bit6_reset_shared,
  input  wire logic             reset_pin_in,
  output logic                  core_reset_request
);

  logic [7:0] p1_latch_reg;
  logic [7:0] p1_latch_next;
  logic [7:0] general_port_mode_bits_reg;
  logic [7:0] general_port_mode_bits_next;
  logic [7:0] p3_latch_reg;
  logic [7:0] p3_latch_next;
  logic [7:0] port3_mode_low_bits_reg;
  logic [7:0] port3_mode_low_bits_next;
  logic [7:0] port3_mode_high_bits_reg;
  logic [7:0] port3_mode_high_bits_next;
  logic [1:0] p4_latch_reg;
  logic [1:0] p4_latch_next;
  logic [1:0] p4_mode_reg;
  logic [1:0] p4_mode_next;
  logic [7:0] pullup_control_reg;
  logic [7:0] pullup_control_next;
  logic [1:0] syscfg_reg;
  logic [1:0] syscfg_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  cpd_pkg::cpd_wb_state_type wb_state_reg;
  cpd_pkg::cpd_wb_state_type wb_state_next;

  logic [NPINS-1:0] latch_vec;
  logic [NPINS-1:0] pullup_vec;
  logic [NPINS-1:0] release_vec;
  logic [NPINS-1:0] pin_sync;
  logic [2*NPINS-1:0] mode_vec;
  logic               wr_en;
  logic               req;
  logic [7:0]         wbyte;

  assign req      = wb_cyc_i && wb_stb_i;
  assign wr_en    = req && wb_we_i && (wb_state_reg == cpd_pkg::CPD_WB_IDLE) && wb_sel_i[0];
  assign wbyte    = wb_dat_i[7:0];
  assign wb_ack_o = (wb_state_reg == cpd_pkg::CPD_WB_ACK);
  assign wb_dat_o = rdata_reg;
  assign crystal_select          = syscfg_reg[`CPD_SYSCFG_XTAL];
  assign port3_bit6_reset_shared = syscfg_reg[`CPD_SYSCFG_RSTGPIO];

  // Reset pin reaches the core only while not borrowed as a port pin
  assign core_reset_request = !port3_bit6_reset_shared && !reset_pin_in;

  // Per-pin vectors: Port 1 at [7:0], Port 3 at [15:8], Port 4 at [17:16]
  always_comb
  begin
    latch_vec   = {p4_latch_reg, p3_latch_reg, p1_latch_reg};
    pullup_vec  = {2'h0, 8'h00, pullup_control_reg};
    release_vec = '0;
    release_vec[17:16] = {2{crystal_select}};
    release_vec[14]    = !port3_bit6_reset_shared;
    for (int i = 0; i < 8; i++)
    begin
      mode_vec[2*i +: 2]       = {1'b0, general_port_mode_bits_reg[i]};
      mode_vec[2*(i+8) +: 2]   = {port3_mode_low_bits_reg[i], port3_mode_high_bits_reg[i]};
    end
    mode_vec[33:32] = {1'b0, p4_mode_reg[0]};
    mode_vec[35:34] = {1'b0, p4_mode_reg[1]};
  end

  // One cell per pin; Port 3 cells decode four modes
  for (genvar g = 0; g < NPINS; g++)
  begin : g_pin
    cpd_pin_cell
    #(
      .FOUR_MODE ((g >= 8) && (g < 16))
    )
    u_cell
    (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .latch_bit    (latch_vec[g]),
      .mode_bits    (mode_vec[2*g +: 2]),
      .pullup_en    (pullup_vec[g]),
      .release_pin  (release_vec[g]),
      .pin_in       (pin_in[g]),
      .pin_sync     (pin_sync[g]),
      .pull_down    (pin_pull_down[g]),
      .strong_up    (pin_strong_up[g]),
      .weak_up      (pin_weak_up[g]),
      .very_weak_up (pin_very_weak_up[g])
    );
  end

  // Register writes and read mux; answer one cycle after the request
  always_comb
  begin
    p1_latch_next               = p1_latch_reg;
    general_port_mode_bits_next = general_port_mode_bits_reg;
    p3_latch_next               = p3_latch_reg;
    port3_mode_low_bits_next    = port3_mode_low_bits_reg;
    port3_mode_high_bits_next   = port3_mode_high_bits_reg;
    p4_latch_next               = p4_latch_reg;
    p4_mode_next                = p4_mode_reg;
    pullup_control_next         = pullup_control_reg;
    syscfg_next                 = syscfg_reg;
    rdata_next                  = rdata_reg;
    wb_state_next               = cpd_pkg::CPD_WB_IDLE;
    if (req && (wb_state_reg == cpd_pkg::CPD_WB_IDLE))
    begin
      wb_state_next = cpd_pkg::CPD_WB_ACK;
      rdata_next    = 32'h0000_0000;
      // Latches read back the latch, pin registers read the sampled pin
      unique case (wb_adr_i)
        `CPD_OFS_P1_LATCH: rdata_next[7:0] = p1_latch_reg;
        `CPD_OFS_P1_MODE:  rdata_next[7:0] = general_port_mode_bits_reg;
        `CPD_OFS_P3_LATCH: rdata_next[7:0] = p3_latch_reg;
        `CPD_OFS_P3_MODE0: rdata_next[7:0] = port3_mode_low_bits_reg;
        `CPD_OFS_P3_MODE1: rdata_next[7:0] = port3_mode_high_bits_reg;
        `CPD_OFS_P4_LATCH: rdata_next[1:0] = p4_latch_reg;
        `CPD_OFS_P4_MODE:  rdata_next[1:0] = p4_mode_reg;
        `CPD_OFS_PULLUP:   rdata_next[7:0] = pullup_control_reg;
        `CPD_OFS_SYSCFG:   rdata_next[1:0] = syscfg_reg;
        `CPD_OFS_P1_PIN:   rdata_next[7:0] = pin_sync[7:0];
        `CPD_OFS_P3_PIN:   rdata_next[7:0] = pin_sync[15:8];
        `CPD_OFS_P4_PIN:   rdata_next[1:0] = pin_sync[17:16];
        default:           rdata_next      = 32'h0000_0000;
      endcase
    end
    if (wr_en)
    begin
      unique case (wb_adr_i)
        `CPD_OFS_P1_LATCH: p1_latch_next               = wbyte;
        `CPD_OFS_P1_MODE:  general_port_mode_bits_next = wbyte;
        `CPD_OFS_P3_LATCH: p3_latch_next               = wbyte;
        `CPD_OFS_P3_MODE0: port3_mode_low_bits_next    = wbyte;
        `CPD_OFS_P3_MODE1: port3_mode_high_bits_next   = wbyte;
        `CPD_OFS_P4_LATCH: p4_latch_next               = wbyte[1:0];
        `CPD_OFS_P4_MODE:  p4_mode_next                = wbyte[1:0];
        `CPD_OFS_PULLUP:   pullup_control_next         = wbyte;
        `CPD_OFS_SYSCFG:   syscfg_next                 = wbyte[1:0];
        default:           p1_latch_next               = p1_latch_reg;
      endcase
    end
  end

  // Registers; latches come up high and modes low so Port 3 pins start weak except released bit 6, Port 1 and 4 undriven
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p1_latch_reg               <= `CPD_RST_LATCH;
      general_port_mode_bits_reg <= `CPD_RST_MODE;
      p3_latch_reg               <= `CPD_RST_LATCH;
      port3_mode_low_bits_reg    <= `CPD_RST_MODE;
      port3_mode_high_bits_reg   <= `CPD_RST_MODE;
      p4_latch_reg               <= `CPD_RST_P4_LATCH;
      p4_mode_reg                <= `CPD_RST_P4_MODE;
      pullup_control_reg         <= `CPD_RST_MODE;
      syscfg_reg                 <= `CPD_RST_SYSCFG;
      rdata_reg                  <= 32'h0000_0000;
      wb_state_reg               <= cpd_pkg::CPD_WB_IDLE;
    end
    else
    begin
      p1_latch_reg               <= p1_latch_next;
      general_port_mode_bits_reg <= general_port_mode_bits_next;
      p3_latch_reg               <= p3_latch_next;
      port3_mode_low_bits_reg    <= port3_mode_low_bits_next;
      port3_mode_high_bits_reg   <= port3_mode_high_bits_next;
      p4_latch_reg               <= p4_latch_next;
      p4_mode_reg                <= p4_mode_next;
      pullup_control_reg         <= pullup_control_next;
      syscfg_reg                 <= syscfg_next;
      rdata_reg                  <= rdata_next;
      wb_state_reg               <= wb_state_next;
    end
  end

endmodule

//--- verif/cpd_port_driver_chk.sv
/*
  Checker for the port pin driver, bound to its top module.
  Assumes 18 pins: Port 1 [7:0], Port 3 [15:8], Port 4 [17:16].
*/
`timescale 1ns/1ps

module cpd_port_driver_chk
#(
  parameter int NPINS = 18
)
(
  input wire logic             mclk,
  input wire logic             rst_n,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_ack_o,
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [NPINS-1:0] pin_pull_down,
  input wire logic [NPINS-1:0] pin_strong_up,
  input wire logic [NPINS-1:0] pin_weak_up,
  input wire logic [NPINS-1:0] pin_very_weak_up,
  input wire logic             crystal_select,
  input wire logic             port3_bit6_reset_shared,
  input wire logic             reset_pin_in,
  input wire logic             core_reset_request
);
  logic [1:0] settle_reg;
  logic [1:0] settle_next;
  logic [NPINS-1:0] any_ctl;

  // Synchroniser still holds reset values for two clocks after release
  always_comb
  begin
    settle_next = (settle_reg == 2'h3) ? settle_reg : settle_reg + 2'h1;
    any_ctl     = pin_pull_down | pin_strong_up | pin_weak_up | pin_very_weak_up;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      settle_reg <= 2'h0;
    else
      settle_reg <= settle_next;
  end

  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_req_start;
    $rose(wb_stb_i) && wb_cyc_i;
  endsequence

  // Port 3 pins, one copy of each check per pin
  for (genvar i = 8; i < 16; i++)
  begin : g_port3
    sequence s_latch_set;
      $fell(pin_pull_down[i]) && pin_very_weak_up[i];
    endsequence
    a_low_no_up: assert property (pin_pull_down[i] |-> !pin_very_weak_up[i] && !pin_weak_up[i])
      else $error("pull-up on beside pull-down");
    a_weak_needs_vw: assert property (pin_weak_up[i] |-> pin_very_weak_up[i])
      else $error("weak pull-up without very weak pull-up");
    a_weak_tracks_pin: assert property (settle_reg == 2'h3 && pin_very_weak_up[i]
      |-> pin_weak_up[i] == $past(pin_in[i], 2)) else $error("weak pull-up not following pin");
    a_boost_one: assert property ($rose(pin_strong_up[i]) && pin_very_weak_up[i] |=> !pin_strong_up[i])
      else $error("boost longer than one clock");
    a_boost_due: assert property (s_latch_set |-> ##[0:1] pin_strong_up[i])
      else $error("no boost after latch set");
  end

  a_drive_excl: assert property (!(|(pin_pull_down & pin_strong_up)))
    else $error("pull-down and strong pull-up together");
  a_xtal_free: assert property (crystal_select |-> any_ctl[17:16] == 2'h0)
    else $error("crystal pins still driven");
  a_rst_pin_free: assert property (!port3_bit6_reset_shared |-> !any_ctl[14])
    else $error("reset pin driven while not shared");
  a_core_reset: assert property (core_reset_request == (!reset_pin_in && !port3_bit6_reset_shared))
    else $error("core reset request wrong");
  a_ack_pulse: assert property (s_req_start |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a one-clock answer");
endmodule

bind cpd_port_driver cpd_port_driver_chk #(.NPINS(NPINS)) chk_u
(
  .mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pin_in, .pin_pull_down, .pin_strong_up, .pin_weak_up,
  .pin_very_weak_up, .crystal_select, .port3_bit6_reset_shared, .reset_pin_in, .core_reset_request
);

//--- verif/cpd_pin_world.sv
/*
  Far side of the pins: resolves drive controls and external sinks to levels.
  Assumes active-high controls; an undriven line wanders every clock.
*/
`timescale 1ns/1ps

module cpd_pin_world
(
  input  wire logic        mclk,
  input  wire logic [17:0] pull_down,
  input  wire logic [17:0] any_up,
  input  wire logic [17:0] ext_low,
  output logic      [17:0] pin_level
);
  logic [17:0] float_reg = 18'h00000;
  logic [17:0] float_next;

  // Floating lines toggle so a stale level never passes for a driven one
  always_comb
  begin
    float_next = ~float_reg;
  end

  always_ff @(posedge mclk)
  begin
    float_reg <= float_next;
  end

  // External sink overpowers any pull-up, as an attached device would
  always_comb
  begin
    pin_level = ~(pull_down | ext_low) & (any_up | float_reg);
  end
endmodule

//--- verif/testbench.sv
/*
  Self-checking bench for the port pin driver over classic Wishbone.
  Assumes the pin world model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "cpd_defines.svh"

module testbench;
  logic        mclk = 1'h0;
  logic        rst_n = 1'h0;
  logic        wb_cyc_i = 1'h0;
  logic        wb_stb_i = 1'h0;
  logic        wb_we_i = 1'h0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [3:0]  sel_val = 4'hF;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [17:0] pin_in, pin_pull_down, pin_strong_up, pin_weak_up, pin_very_weak_up;
  logic [17:0] ext_low = 18'h00000;
  logic        crystal_select, port3_bit6_reset_shared, core_reset_request;
  logic        reset_pin_in = 1'h1;
  int          n_fail = 0;
  int          checks_done = 0;
  int          boost_cnt = 0;

  cpd_port_driver #(.NPINS(18)) dut_u
  (
    .mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .pin_in, .pin_pull_down, .pin_strong_up, .pin_weak_up, .pin_very_weak_up,
    .crystal_select, .port3_bit6_reset_shared, .reset_pin_in, .core_reset_request
  );

  cpd_pin_world world_u
  (
    .mclk, .pull_down(pin_pull_down), .any_up(pin_strong_up | pin_weak_up | pin_very_weak_up),
    .ext_low, .pin_level(pin_in)
  );

  always #2.5 mclk = ~mclk;

  // Counts boost clocks on Port 3 bit 0, sampled mid-cycle
  always @(negedge mclk)
    if (pin_strong_up[8] === 1'h1)
      boost_cnt++;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] ctl(input int p);
    return {28'h0000000, pin_pull_down[p], pin_strong_up[p], pin_weak_up[p], pin_very_weak_up[p]};
  endfunction

  // One classic cycle; waits on ack, the watchdog bounds a hang
  task automatic wb_cycle(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge mclk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= wr;
    wb_adr_i <= a;
    wb_sel_i <= sel_val;
    wb_dat_i <= {24'h000000, d};
    do @(posedge mclk); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i  <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    wb_cycle(1'h0, a, 8'h00, q);
    chk("read data", e, q & m);
  endtask

  // Write, let the sync path settle, then judge one pin's controls
  task automatic step(input logic [7:0] a, input logic [7:0] d, input int p, input logic [31:0] e);
    logic [31:0] q;
    wb_cycle(1'h1, a, d, q);
    repeat (4) @(negedge mclk);
    chk("pin controls", e, ctl(p));
  endtask

  task automatic t_reset_values();
    logic [31:0] q;
    rd(`CPD_OFS_P1_LATCH, 32'hFF, 32'hFFFFFFFF);
    // A write without byte lane zero must leave the latch alone
    sel_val = 4'hE;
    wb_cycle(1'h1, `CPD_OFS_P1_LATCH, 8'h00, q);
    sel_val = 4'hF;
    rd(`CPD_OFS_P1_LATCH, 32'hFF, 32'hFFFFFFFF);
    rd(`CPD_OFS_P3_MODE0, 32'h00, 32'hFFFFFFFF);
    rd(`CPD_OFS_P4_LATCH, 32'h03, 32'hFFFFFFFF);
    rd(`CPD_OFS_SYSCFG, 32'h00, 32'hFFFFFFFF);
    rd(8'h3C, 32'h00, 32'hFFFFFFFF);
    @(negedge mclk);
    chk("quasi idle", 32'h3, ctl(8));
    chk("reset pin idle", 32'h0, ctl(14));
    chk("reset shared", 32'h0, {31'h00000000, port3_bit6_reset_shared});
  endtask

  task automatic t_quasi();
    step(`CPD_OFS_P3_LATCH, 8'hFE, 8, 32'h8);
    boost_cnt = 0;
    step(`CPD_OFS_P3_LATCH, 8'hFF, 8, 32'h3);
    chk("boost clocks", 32'h1, boost_cnt);
    @(posedge mclk);
    ext_low[8] <= 1'h1;
    repeat (4) @(negedge mclk);
    chk("pulled low", 32'h1, ctl(8));
    rd(`CPD_OFS_P3_PIN, 32'h0, 32'h1);
    @(posedge mclk);
    ext_low[8] <= 1'h0;
  endtask

  task automatic t_modes();
    logic [31:0] e_lo [4] = '{32'h8, 32'h8, 32'h0, 32'h8};
    logic [31:0] e_hi [4] = '{32'h3, 32'h4, 32'h0, 32'h0};
    logic [31:0] q;
    for (int m = 0; m < 4; m++)
    begin
      wb_cycle(1'h1, `CPD_OFS_P3_MODE0, m[1] ? 8'h02 : 8'h00, q);
      wb_cycle(1'h1, `CPD_OFS_P3_MODE1, m[0] ? 8'h02 : 8'h00, q);
      step(`CPD_OFS_P3_LATCH, 8'hFD, 9, e_lo[m]);
      step(`CPD_OFS_P3_LATCH, 8'hFF, 9, e_hi[m]);
      chk("neighbour pin", 32'h3, ctl(8));
      if (m == 1)
        rd(`CPD_OFS_P3_PIN, 32'h2, 32'h2);
    end
  endtask

  task automatic t_general();
    step(`CPD_OFS_P1_LATCH, 8'hFE, 0, 32'h8);
    step(`CPD_OFS_P1_LATCH, 8'hFF, 0, 32'h0);
    step(`CPD_OFS_PULLUP, 8'h01, 0, 32'h2);
    step(`CPD_OFS_PULLUP, 8'h00, 0, 32'h0);
    step(`CPD_OFS_P1_MODE, 8'h01, 0, 32'h4);
    step(`CPD_OFS_P1_LATCH, 8'hFE, 0, 32'h8);
  endtask

  task automatic t_shared_pins();
    step(`CPD_OFS_P4_MODE, 8'h03, 16, 32'h4);
    step(`CPD_OFS_SYSCFG, 8'h01, 16, 32'h0);
    chk("crystal select", 32'h1, {31'h00000000, crystal_select});
    chk("crystal in pin", 32'h0, ctl(17));
    @(posedge mclk);
    reset_pin_in <= 1'h0;
    @(negedge mclk);
    chk("core reset", 32'h1, {31'h00000000, core_reset_request});
    step(`CPD_OFS_SYSCFG, 8'h02, 14, 32'h3);
    chk("reset shared", 32'h1, {31'h00000000, port3_bit6_reset_shared});
    chk("core reset", 32'h0, {31'h00000000, core_reset_request});
    @(posedge mclk);
    reset_pin_in <= 1'h1;
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'h1;
    t_reset_values();
    t_quasi();
    t_modes();
    t_general();
    t_shared_pins();
    print_verdict();
  end

  // Run needs about two hundred clocks; this span is twenty times that
  initial
  begin
    #20000;
    n_fail++;
    print_verdict();
  end
endmodule
